// [hw/two_wire_slave_interface.sv]
// two-wire bus slave: address match, byte engine and register side
// Contract
// (R1) works at standard and fast bus rates
// (R2) master starts only on idle bus
// (R3) data change with clock high is control
// (R4) data falling, clock high, is start
// (R5) data rising, clock high, is stop
// (R6) data changes only while clock low
// (R7) any byte count between start and stop
// (R8) eight bits then one acknowledge slot
// (R9) master clocks the acknowledge slot
// (R10) acknowledger holds data low through high
// (R11) after master nack, slave releases data
// (R12) write: address, data bytes, each acknowledged
// (R13) bytes travel most significant bit first
// (R14) master acks all but last read byte
// (R15) repeated start begins a new transfer
// (R16) first byte: seven address bits, direction
// (R17) one address bit from strap pin
// (R18) direction zero write, one read
// (R19) matching address acknowledged in both directions
// (R20) transmit bytes on master clock edges
// (R21) command byte selects accessed register
// (R22) pointer never advances, resend command
// (R23) one temperature byte may suffice
// (R24) no match: release, wait for condition
// (R25) synchronise and filter lines before edges
`timescale 1ns/1ps
`include "tws_map.svh"
module two_wire_slave_interface
   import tws_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_LINK_CLK,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic I_ADDRESS_STRAP_PIN,
   input wire logic [15:0] I_TEMPERATURE,
   output logic O_SDA,
   output logic O_SDA_OE_N,
   output logic O_BUS_BUSY,
   output logic [7:0] O_FREQ_SELECT,
   output logic [7:0] O_OSC_CONTROL,
   output logic [7:0] O_FREQ_TUNING
);

   // ---------------- helpers ----------------

   // byte the master reads for a given pointer; later bytes of temperature are the fraction
   function automatic byte_t read_byte(input byte_t ptr, input logic later, input snap_t s);
      byte_t r;
      r = `TWS_UNMAPPED_BYTE;
      if (ptr == `TWS_CMD_FREQ_SELECT) begin
         r = s.freq_select;
      end else if (ptr == `TWS_CMD_OSC_CONTROL) begin
         r = s.osc_control;
      end else if (ptr == `TWS_CMD_FREQ_TUNING) begin
         r = s.freq_tuning;
      end else if (ptr == `TWS_CMD_TEMPERATURE) begin
         r = later ? s.temperature[7:0] : s.temperature[15:8]; // see (R21) see (R23)
      end
      return r;
   endfunction : read_byte

   // seven address bits sit above the direction bit, strap in the lowest
   function automatic logic addr_match(input byte_t rx, input logic strap);
      return rx[7:1] == {`TWS_ADDR_HIGH, strap}; // see (R16) see (R17)
   endfunction : addr_match

   // ---------------- link domain reset and strap ----------------

   logic rst_s1_q; // first reset sync stage
   logic rst_l; // reset seen by link logic
   logic strap_s1_q; // first strap sync stage
   logic strap_q; // synchronised strap level

   // the strap is a pin, so it passes two flops like the bus lines
   always_ff @(posedge I_LINK_CLK) begin
      rst_s1_q <= I_SYS_RST;
      rst_l <= rst_s1_q;
      strap_s1_q <= I_ADDRESS_STRAP_PIN;
      strap_q <= strap_s1_q;
   end

   bus_view_if bv ();

   // oversampling keeps up with both bus rates, no rate setting needed
   line_conditioner u_cond ( // see (R1)
      .i_clk (I_LINK_CLK),
      .i_rst (rst_l),
      .i_scl (I_SCL),
      .i_sda (I_SDA),
      .bv (bv.cond)
   );

   // ---------------- link domain protocol engine ----------------

   state_t state_q, state_d; // engine state
   logic [3:0] cnt_q, cnt_d; // clock rises since last byte boundary
   byte_t rx_q, rx_d; // receive shifter
   byte_t tx_q, tx_d; // transmit shifter, msb on the line
   logic rw_q, rw_d; // direction of current transfer
   logic cmd_q, cmd_d; // next written byte is a command
   byte_t ptr_q, ptr_d; // register pointer, kept across transfers
   logic later_q, later_d; // first read byte already sent
   logic nack_q, nack_d; // master left the ack slot high
   logic oe_n_q, oe_n_d; // data pin enable, low pulls the line
   logic busy_q, busy_d; // between a start and a stop
   logic wr_tog_q, wr_tog_d; // flips once per register write
   byte_t wr_addr_q, wr_addr_d; // held until the next write
   byte_t wr_data_q, wr_data_d;
   logic req_tog_q, req_tog_d; // asks core for a fresh snapshot
   logic [2:0] ack_s_q; // snapshot done toggle sync and history
   logic ack_tog_q, ack_tog_d; // snapshot done toggle, flipped in the core domain
   snap_t snap_l_q; // snapshot as seen by the engine
   snap_t snap_c_q; // snapshot captured in the core domain

   // next-state logic of the byte engine
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      tx_d = tx_q;
      rw_d = rw_q;
      cmd_d = cmd_q;
      ptr_d = ptr_q;
      later_d = later_q;
      nack_d = nack_q;
      busy_d = busy_q;
      wr_tog_d = wr_tog_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      req_tog_d = req_tog_q;
      if (bv.start) begin
         // a repeated start restarts from any state, bus stays owned
         state_d = ST_ADDR; // see (R4) see (R15)
         cnt_d = 4'h0;
         busy_d = 1'b1;
         cmd_d = 1'b1;
         later_d = 1'b0;
         req_tog_d = ~req_tog_q;
      end else if (bv.stop) begin
         state_d = ST_IDLE; // see (R5)
         busy_d = 1'b0;
      end else begin
         // sample on rising clock, msb arrives first
         if (bv.scl_rise) begin
            rx_d = {rx_q[6:0], bv.sda}; // see (R13) see (R6)
            cnt_d = cnt_q + 4'h1;
         end
         case (state_q)
            ST_ADDR: begin
               if (bv.scl_fall && (cnt_q == `TWS_BYTE_BITS)) begin
                  cnt_d = 4'h0;
                  rw_d = rx_q[`TWS_DIR_BIT]; // see (R18)
                  // ack on match whatever the direction
                  if (addr_match(rx_q, strap_q)) begin
                     state_d = ST_ACK; // see (R19)
                  end else begin
                     state_d = ST_IGNORE; // see (R24)
                  end
               end
            end
            ST_RX: begin
               if (bv.scl_fall && (cnt_q == `TWS_BYTE_BITS)) begin
                  cnt_d = 4'h0;
                  state_d = ST_ACK; // see (R12) see (R8)
                  if (cmd_q) begin
                     // first byte picks the register; pointer is never bumped
                     ptr_d = rx_q; // see (R21) see (R22)
                     cmd_d = 1'b0;
                  end else begin
                     // unlimited data bytes, each written to the same register
                     wr_tog_d = ~wr_tog_q; // see (R7)
                     wr_addr_d = ptr_q;
                     wr_data_d = rx_q;
                  end
               end
            end
            ST_ACK: begin
               // the ninth pulse ends here; line changes only while low
               if (bv.scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     tx_d = read_byte(ptr_q, later_q, snap_l_q); // see (R20)
                     state_d = ST_TX;
                  end else begin
                     state_d = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (bv.scl_fall) begin
                  if (cnt_q == `TWS_BYTE_BITS) begin
                     cnt_d = 4'h0;
                     state_d = ST_TX_ACK; // see (R8) see (R9)
                  end else begin
                     tx_d = {tx_q[6:0], 1'b0}; // see (R13) see (R20)
                  end
               end
            end
            ST_TX_ACK: begin
               if (bv.scl_rise) begin
                  nack_d = bv.sda; // see (R14)
               end
               if (bv.scl_fall) begin
                  cnt_d = 4'h0;
                  if (nack_q) begin
                     state_d = ST_IGNORE; // see (R11)
                  end else begin
                     later_d = 1'b1;
                     tx_d = read_byte(ptr_q, 1'b1, snap_l_q);
                     state_d = ST_TX;
                  end
               end
            end
            default: begin
               // idle and ignore wait for a start or stop only
            end
         endcase
      end
      // pull low only while acknowledging or sending a zero
      oe_n_d = ~((state_d == ST_ACK) || ((state_d == ST_TX) && ~tx_d[7])); // see (R10)
   end

   // registers of the byte engine
   always_ff @(posedge I_LINK_CLK) begin
      if (rst_l) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'hFF;
         rw_q <= 1'b0;
         cmd_q <= 1'b0;
         ptr_q <= 8'h00;
         later_q <= 1'b0;
         nack_q <= 1'b0;
         oe_n_q <= 1'b1;
         busy_q <= 1'b0;
         wr_tog_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         req_tog_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         rw_q <= rw_d;
         cmd_q <= cmd_d;
         ptr_q <= ptr_d;
         later_q <= later_d;
         nack_q <= nack_d;
         oe_n_q <= oe_n_d;
         busy_q <= busy_d;
         wr_tog_q <= wr_tog_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         req_tog_q <= req_tog_d;
      end
   end

   // snapshot arrives by toggle; the word is stable long before the first read bit
   always_ff @(posedge I_LINK_CLK) begin
      if (rst_l) begin
         ack_s_q <= 3'h0;
         snap_l_q <= '0;
      end else begin
         ack_s_q <= {ack_s_q[1:0], ack_tog_q};
         if (ack_s_q[2] != ack_s_q[1]) begin
            snap_l_q <= snap_c_q;
         end
      end
   end

   assign O_SDA = 1'b0; // open drain, only the enable moves
   assign O_SDA_OE_N = oe_n_q;
   assign O_BUS_BUSY = busy_q;

   // ---------------- core domain register side ----------------

   logic [2:0] wr_s_q; // write toggle sync and history
   logic [2:0] req_s_q; // snapshot request sync and history
   snap_t snap_c_d;
   byte_t fsel_q, fsel_d; // frequency select register
   byte_t octl_q, octl_d; // oscillator control register
   byte_t tune_q, tune_d; // frequency tuning register

   // writes land by pointer; temperature is read-only and unknown codes drop
   always_comb begin
      fsel_d = fsel_q;
      octl_d = octl_q;
      tune_d = tune_q;
      snap_c_d = snap_c_q;
      ack_tog_d = ack_tog_q;
      if (wr_s_q[2] != wr_s_q[1]) begin
         if (wr_addr_q == `TWS_CMD_FREQ_SELECT) begin // see (R21)
            fsel_d = wr_data_q;
         end else if (wr_addr_q == `TWS_CMD_OSC_CONTROL) begin
            octl_d = wr_data_q;
         end else if (wr_addr_q == `TWS_CMD_FREQ_TUNING) begin
            tune_d = wr_data_q;
         end
      end
      // capture after any pending write, both syncs have equal latency
      if (req_s_q[2] != req_s_q[1]) begin
         snap_c_d = '{freq_select: fsel_d, osc_control: octl_d,
            freq_tuning: tune_d, temperature: I_TEMPERATURE};
         ack_tog_d = ~ack_tog_q;
      end
   end

   // core registers
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         wr_s_q <= 3'h0;
         req_s_q <= 3'h0;
         ack_tog_q <= 1'b0;
         snap_c_q <= '0;
         fsel_q <= `TWS_RST_FREQ_SELECT;
         octl_q <= `TWS_RST_OSC_CONTROL;
         tune_q <= `TWS_RST_FREQ_TUNING;
      end else begin
         wr_s_q <= {wr_s_q[1:0], wr_tog_q};
         req_s_q <= {req_s_q[1:0], req_tog_q};
         ack_tog_q <= ack_tog_d;
         snap_c_q <= snap_c_d;
         fsel_q <= fsel_d;
         octl_q <= octl_d;
         tune_q <= tune_d;
      end
   end

   assign O_FREQ_SELECT = fsel_q;
   assign O_OSC_CONTROL = octl_q;
   assign O_FREQ_TUNING = tune_q;

   // ---------------- checks ----------------

   AST_START_TO_ADDR: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R4)
      bv.start |=> (state_q == ST_ADDR) && busy_q && (cnt_q == 4'h0))
      else $error("start did not open address phase");

   AST_STOP_TO_IDLE: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R5)
      (bv.stop && !bv.start) |=> (state_q == ST_IDLE) && !busy_q && oe_n_q)
      else $error("stop did not end the transfer");

   AST_ACK_HELD_LOW: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R10)
      ((state_q == ST_ACK) && bv.scl_rise) |-> !oe_n_q throughout
         (bv.scl [*2]))
      else $error("acknowledge not low through clock high");

   AST_CHANGE_WHILE_LOW: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R6)
      ($changed(oe_n_q) && !$past(bv.start) && !$past(bv.stop)) |-> !bv.scl)
      else $error("data pin moved while clock high");

   AST_MATCH_ACKS: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R19)
      ((state_q == ST_ADDR) && bv.scl_fall && (cnt_q == 4'h8) && !bv.start
         && addr_match(rx_q, strap_q)) |=> (state_q == ST_ACK) ##0 !oe_n_q)
      else $error("matching address not acknowledged");

   AST_MISS_RELEASES: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R24)
      ((state_q == ST_ADDR) && bv.scl_fall && (cnt_q == 4'h8) && !bv.start
         && !addr_match(rx_q, strap_q)) |=> (state_q == ST_IGNORE) && oe_n_q)
      else $error("foreign address not ignored");

   AST_READ_DIR_TX: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R18)
      ((state_q == ST_ACK) && bv.scl_fall && !bv.start && !bv.stop)
         |=> (state_q == (rw_q ? ST_TX : ST_RX)))
      else $error("direction bit not followed");

   AST_NACK_RELEASE: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R11)
      ((state_q == ST_TX_ACK) && bv.scl_fall && nack_q && !bv.start && !bv.stop)
         |=> oe_n_q ##1 oe_n_q)
      else $error("data pin held after master nack");

   AST_TX_MSB_FIRST: assert property (@(posedge I_LINK_CLK) disable iff (rst_l) // see (R13)
      ((state_q == ST_TX) && bv.scl_rise) |-> (oe_n_q == tx_q[7]))
      else $error("transmitted bit is not the shifter msb");

endmodule : two_wire_slave_interface

// [hw/tws_map.svh]
// offsets, reset values, bit positions and timing counts of the two-wire slave
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// bus rates the engine must follow, in kHz
`define TWS_STD_RATE_KHZ 100
`define TWS_FAST_RATE_KHZ 400

// command codes selecting the register behind the pointer
`define TWS_CMD_FREQ_SELECT 8'h5D
`define TWS_CMD_OSC_CONTROL 8'h60
`define TWS_CMD_TEMPERATURE 8'h64
`define TWS_CMD_FREQ_TUNING 8'h66

// reset values of the writable registers
`define TWS_RST_FREQ_SELECT 8'h00
`define TWS_RST_OSC_CONTROL 8'h00
`define TWS_RST_FREQ_TUNING 8'h00

// answer for a read through an unknown command code
`define TWS_UNMAPPED_BYTE 8'hFF

// upper six bits of the slave address; value is arbitrary
`define TWS_ADDR_HIGH 6'h2A

// direction bit position inside the address byte
`define TWS_DIR_BIT 0

// bits per byte before the acknowledge slot
`define TWS_BYTE_BITS 4'h8

// link sampling clock period and spike suppression time
`define TWS_LINK_PERIOD_PS 12000
`define TWS_SPIKE_NS 50
`define TWS_FILT_CYC ((`TWS_SPIKE_NS * 1000) / `TWS_LINK_PERIOD_PS)

`endif

// [hw/tws_pkg.sv]
// types shared by the two-wire slave modules
package tws_pkg;

   typedef logic [7:0] byte_t;

   // snapshot of the readable registers carried into the link domain
   typedef struct packed {
      byte_t freq_select;
      byte_t osc_control;
      byte_t freq_tuning;
      logic [15:0] temperature;
   } snap_t;

   // protocol engine states, gray along idle-addr-ack-rx and ack-tx-txack
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ADDR   = 3'h1,
      ST_ACK    = 3'h3,
      ST_RX     = 3'h2,
      ST_TX     = 3'h7,
      ST_TX_ACK = 3'h6,
      ST_IGNORE = 3'h5
   } state_t;

endpackage : tws_pkg

// [hw/bus_view_if.sv]
// conditioned view of the bus lines passed from conditioner to engine
`timescale 1ns/1ps
interface bus_view_if;
   logic scl; // filtered clock line level
   logic sda; // filtered data line level
   logic scl_rise; // one-cycle pulse, clock line went high
   logic scl_fall; // one-cycle pulse, clock line went low
   logic start; // data fell while clock high
   logic stop; // data rose while clock high

   modport cond (output scl, output sda, output scl_rise, output scl_fall,
      output start, output stop);
   modport engine (input scl, input sda, input scl_rise, input scl_fall,
      input start, input stop);
endinterface : bus_view_if

// [hw/line_conditioner.sv]
// synchroniser, spike filter and condition detector for the bus lines
`timescale 1ns/1ps
`include "tws_map.svh"
module line_conditioner
   import tws_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   bus_view_if.cond bv
);
   // index 0 is the clock line, index 1 the data line
   logic [1:0] s1_q; // first sync stage, read only by s2_q
   logic [1:0] s2_q; // second sync stage
   logic [1:0] filt_q, filt_d; // filtered levels
   logic [2:0] cnt_q [2]; // disagreement run length
   logic [2:0] cnt_d [2];
   logic [4:0] ev_q, ev_d; // rise, fall, start, stop, spare

   // a level only moves after it disagreed for TWS_FILT_CYC samples in a row, four link clock samples
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         filt_d[i] = filt_q[i];
         cnt_d[i] = 3'h0;
         if (s2_q[i] != filt_q[i]) begin
            if (cnt_q[i] == 3'(`TWS_FILT_CYC - 1)) begin // see (R25)
               filt_d[i] = s2_q[i];
            end else begin
               cnt_d[i] = cnt_q[i] + 3'h1;
            end
         end
      end
      ev_d[0] = filt_d[0] & ~filt_q[0];
      ev_d[1] = ~filt_d[0] & filt_q[0];
      // data moving while the clock stays high is a control condition
      ev_d[2] = filt_q[0] & filt_d[0] & filt_q[1] & ~filt_d[1]; // see (R3) see (R4)
      ev_d[3] = filt_q[0] & filt_d[0] & ~filt_q[1] & filt_d[1]; // see (R5)
      ev_d[4] = 1'b0;
   end

   // registers only; idle bus reads high on both lines
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         filt_q <= 2'h3;
         cnt_q[0] <= 3'h0;
         cnt_q[1] <= 3'h0;
         ev_q <= 5'h00;
      end else begin
         s1_q <= {i_sda, i_scl}; // see (R25)
         s2_q <= s1_q;
         filt_q <= filt_d;
         cnt_q[0] <= cnt_d[0];
         cnt_q[1] <= cnt_d[1];
         ev_q <= ev_d;
      end
   end

   assign bv.scl = filt_q[0];
   assign bv.sda = filt_q[1];
   assign bv.scl_rise = ev_q[0];
   assign bv.scl_fall = ev_q[1];
   assign bv.start = ev_q[2];
   assign bv.stop = ev_q[3];

   // a filtered edge always follows at least two agreeing samples
   AST_FILT_STABLE: assert property (@(posedge i_clk) disable iff (i_rst) // see (R25)
      $changed(filt_q[0]) |-> ($past(s2_q[0], 1) == filt_q[0])
         && ($past(s2_q[0], 2) == filt_q[0]))
      else $error("clock line filter passed a short spike");

endmodule : line_conditioner

// [bench/tw_master.sv]
// two-wire bus master model that drives the clock and data lines
`timescale 1ns/1ps
module tw_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   int tlo = 1300; // clock low time, fast rate by default
   int thi = 600; // clock high time
   int unstable = 0; // data moves seen while clock high
   // idle bus, both lines released
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // waits on falling core edges so line changes keep clear of sampling
   task automatic wt(input int ns);
      repeat (ns / 4) @(negedge i_clk);
   endtask : wt
   // one pulse; data moves a quarter into the low time, never beside the clock edge
   task automatic pulse(input logic b, output logic [1:0] s);
      wt(tlo / 4);
      o_sda = b;
      wt(3 * tlo / 4);
      o_scl = 1'b1;
      wt(thi / 4);
      s[1] = i_sda;
      wt(thi / 2);
      s[0] = i_sda;
      if (s[1] !== s[0]) unstable++;
      wt(thi / 4);
      o_scl = 1'b0;
   endtask : pulse
   // data falls while clock high; also serves as repeated start
   task automatic start();
      wt(tlo / 4);
      o_sda = 1'b1;
      wt(tlo);
      o_scl = 1'b1;
      wt(thi);
      o_sda = 1'b0;
      wt(thi);
      o_scl = 1'b0;
   endtask : start
   // data rises while clock high
   task automatic stop();
      wt(tlo / 4);
      o_sda = 1'b0;
      wt(tlo);
      o_scl = 1'b1;
      wt(thi);
      o_sda = 1'b1;
      wt(thi);
   endtask : stop
   // eight bits msb first, then a released acknowledge slot
   task automatic byte_out(input logic [7:0] b, output logic [1:0] ack);
      for (int i = 7; i >= 0; i--) pulse(b[i], ack);
      pulse(1'b1, ack);
   endtask : byte_out
   // low acknowledges, high ends the read
   task automatic byte_in(input logic ack, output logic [7:0] d);
      logic [1:0] s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, s);
         d[i] = s[0];
      end
      pulse(!ack, s);
   endtask : byte_in
endmodule : tw_master

// [bench/test_two_wire_slave_interface.sv]
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
`include "tws_map.svh"
module test_two_wire_slave_interface;
   import tws_pkg::*;
   logic clk = 1'b0; // core clock
   logic link_clk = 1'b0; // link sampling clock
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic [15:0] temp = 16'h0000;
   logic scl, sda_m, sda, o_sda, oe_n, busy;
   logic [7:0] fsel, octl, ftun;
   int fail_count = 0;
   int check_count = 0;
   assign sda = sda_m & (oe_n | o_sda); // wired-and with pull-up
   initial forever #2 clk = ~clk;
   // unrelated phase to the core clock
   initial begin
      #5.3;
      forever #6 link_clk = ~link_clk;
   end
   tw_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
   two_wire_slave_interface dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_LINK_CLK(link_clk),
      .I_SCL(scl), .I_SDA(sda), .I_ADDRESS_STRAP_PIN(strap), .I_TEMPERATURE(temp),
      .O_SDA(o_sda), .O_SDA_OE_N(oe_n), .O_BUS_BUSY(busy), .O_FREQ_SELECT(fsel),
      .O_OSC_CONTROL(octl), .O_FREQ_TUNING(ftun));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   // address byte: six fixed bits, strap bit, direction
   function automatic logic [7:0] addr(input logic s, input logic rd);
      return {`TWS_ADDR_HIGH, s, rd};
   endfunction : addr
   // send a byte, ack must read low at both samples of the high phase when ackd, high at both when not
   task automatic tx(input logic [7:0] b, input logic ackd);
      logic [1:0] a;
      m.byte_out(b, a);
      check("ack", 16'(a), ackd ? 16'h0000 : 16'h0003);
   endtask : tx
   task automatic rx(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      m.byte_in(ack, d);
      check("rdata", 16'(d), 16'(exp));
   endtask : rx
   // read through a command with repeated start; pointer resent each time
   task automatic rd2(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
      m.start();
      tx(addr(strap, 1'b0), 1'b1);
      tx(cmd, 1'b1);
      m.start();
      check("busy", 16'(busy), 16'h0001);
      tx(addr(strap, 1'b1), 1'b1);
      rx(1'b1, e0);
      rx(1'b0, e1);
      m.wt(m.tlo);
      check("release", 16'(oe_n), 16'h0001);
      m.stop();
   endtask : rd2
   initial begin
      #1000000;
      fail_count++;
      finish_test();
   end
   initial begin
      logic [7:0] v[3];
      logic [7:0] cmds[3];
      cmds = '{`TWS_CMD_FREQ_SELECT, `TWS_CMD_OSC_CONTROL, `TWS_CMD_FREQ_TUNING};
      void'($urandom(32'h4848));
      @(negedge clk);
      strap = 1'($urandom);
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (30) @(negedge clk);
      check("oe_n", 16'(oe_n), 16'h0001);
      check("busy", 16'(busy), 16'h0000);
      check("fsel", 16'(fsel), 16'(`TWS_RST_FREQ_SELECT));
      check("octl", 16'(octl), 16'(`TWS_RST_OSC_CONTROL));
      check("ftun", 16'(ftun), 16'(`TWS_RST_FREQ_TUNING));
      // write every writable register; the first one gets two data bytes
      foreach (cmds[i]) begin
         v[i] = 8'($urandom);
         m.start();
         check("busy", 16'(busy), 16'h0001);
         tx(addr(strap, 1'b0), 1'b1);
         tx(cmds[i], 1'b1);
         if (i == 0) tx(~v[i], 1'b1);
         tx(v[i], 1'b1);
         m.stop();
         check("busy", 16'(busy), 16'h0000);
      end
      check("fsel", 16'(fsel), 16'(v[0]));
      check("octl", 16'(octl), 16'(v[1]));
      check("ftun", 16'(ftun), 16'(v[2]));
      rd2(`TWS_CMD_FREQ_TUNING, v[2], v[2]);
      temp = 16'($urandom);
      rd2(`TWS_CMD_TEMPERATURE, temp[15:8], temp[7:0]);
      // the other strap address must be left alone
      m.start();
      tx(addr(!strap, 1'b0), 1'b0);
      m.stop();
      // standard rate address match
      m.tlo = 4700;
      m.thi = 4000;
      m.start();
      tx(addr(strap, 1'b0), 1'b1);
      m.stop();
      check("stable", 16'(m.unstable), 16'h0000);
      finish_test();
   end
endmodule : test_two_wire_slave_interface
